// >>> shared/indicator_cfg_pkg.sv
package indicator_cfg_pkg;

    // ==========================================================
    // register indices and byte addresses
    // ==========================================================
    localparam logic [11:0] indicator_output_control_idx = 12'h469;
    localparam logic [11:0] line_polarity_override_idx   = 12'h475;
    localparam logic [11:0] monitor_period_config_idx    = 12'h480;
    localparam logic [11:0] monitor_run_control_idx      = 12'h481;
    localparam logic [13:0] indicator_output_control_addr = {indicator_output_control_idx, 2'b00};
    localparam logic [13:0] line_polarity_override_addr   = {line_polarity_override_idx, 2'b00};
    localparam logic [13:0] monitor_period_config_addr    = {monitor_period_config_idx, 2'b00};
    localparam logic [13:0] monitor_run_control_addr      = {monitor_run_control_idx, 2'b00};

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int polarity_bit_2     = 10;
    localparam int ovr_value_bit_2    = 9;
    localparam int ovr_enable_bit_2   = 8;
    localparam int polarity_bit_1     = 6;
    localparam int ovr_value_bit_1    = 5;
    localparam int ovr_enable_bit_1   = 4;
    localparam int polarity_bit_0     = 2;
    localparam int ovr_value_bit_0    = 1;
    localparam int ovr_enable_bit_0   = 0;
    localparam int pol_value_bit      = 13;
    localparam int pol_force_bit      = 12;
    localparam int periodic_bit       = 1;
    localparam int start_bit          = 0;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [3:0]  period_reset        = 4'h2;
    localparam logic        periodic_reset      = 1'b1;
    localparam logic [13:0] run_ctrl_rsvd_reset = 14'h0028;
    localparam logic        third_pol_reset     = 1'b0;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int clk_period_ns     = 100;
    localparam int period_unit_ms    = 16;
    localparam int period_unit_cyc   = period_unit_ms * 1000000 / clk_period_ns;

    // ==========================================================
    // bus responses
    // ==========================================================
    localparam logic [1:0] resp_okay   = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        mon_idle = 3'b001,
        mon_wait = 3'b010,
        mon_fire = 3'b100
    } mon_state_t;

    typedef struct packed {
        logic [2:0] polarity;
        logic [2:0] ovr_value;
        logic [2:0] ovr_enable;
    } indicator_cfg_t;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic       pol_value;
        logic       pol_force;
        logic [11:0] rsvd_lo;
    } line_pol_t;

    typedef struct packed {
        indicator_cfg_t ind;
        line_pol_t      lpol;
        logic [3:0]     period;
        logic [13:0]    run_rsvd;
        logic           periodic;
        logic           start;
        mon_state_t     mon;
        logic [23:0]    unit_cnt;
        logic [3:0]     per_cnt;
        logic           mon_trig;
        logic [2:0]     light;
        logic           busy;
        logic           rev;
        logic [2:0]     act_s1;
        logic [2:0]     act_s2;
        logic [2:0]     act_s3;
        logic [2:0]     act_ok;
        logic [1:0]     strap_done;
        logic           aw_ok;
        logic [13:0]    aw_addr;
        logic           w_ok;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } state_t;

endpackage

// >>> src/indicator_cfg_regs.sv
`timescale 1ns/10ps
module indicator_cfg_regs
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  strap_polarity,
    input  wire logic [2:0]  light_active,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [2:0]       status_light,
    output logic             auto_polarity_off,
    output logic             line_polarity_reversed,
    output logic             monitor_trigger,
    output logic             monitor_busy
);

    // ==========================================================
    // state
    // ==========================================================
    indicator_cfg_pkg::state_t st_reg;
    indicator_cfg_pkg::state_t st_next;

    logic        wr_go;
    logic [31:0] wr_val;
    logic [15:0] rd_val;
    logic        rd_hit;
    logic        wr_hit;
    logic        unit_tick;
    logic        start_wr;

    // ==========================================================
    // read mux
    // ==========================================================
    always_comb
    begin
        rd_val = 16'h0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            indicator_cfg_pkg::indicator_output_control_addr:
            begin
                for (int i = 0; i < 3; i++)
                begin
                    rd_val[4*i+2] = st_reg.ind.polarity[i];
                    rd_val[4*i+1] = st_reg.ind.ovr_value[i];
                    rd_val[4*i]   = st_reg.ind.ovr_enable[i];
                end
            end
            indicator_cfg_pkg::line_polarity_override_addr:
                rd_val = st_reg.lpol;
            indicator_cfg_pkg::monitor_period_config_addr:
                rd_val = {12'h000, st_reg.period};
            indicator_cfg_pkg::monitor_run_control_addr:
                rd_val = {st_reg.run_rsvd, st_reg.periodic, st_reg.start};
            default:
                rd_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        st_next = st_reg;
        wr_val = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            wr_val[8*b +: 8] = st_reg.w_strb[b] ? st_reg.w_data[8*b +: 8] : 8'h00;
        end
        wr_go = st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid;
        wr_hit = (st_reg.aw_addr == indicator_cfg_pkg::indicator_output_control_addr)
              || (st_reg.aw_addr == indicator_cfg_pkg::line_polarity_override_addr)
              || (st_reg.aw_addr == indicator_cfg_pkg::monitor_period_config_addr)
              || (st_reg.aw_addr == indicator_cfg_pkg::monitor_run_control_addr);
        start_wr = 1'b0;
        unit_tick = (st_reg.unit_cnt == 24'(indicator_cfg_pkg::period_unit_cyc - 1));

        // write channel capture
        if (s_axi_awvalid && !st_reg.aw_ok)
        begin
            st_next.aw_ok = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_ok)
        begin
            st_next.w_ok = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = wr_hit ? indicator_cfg_pkg::resp_okay
                                   : indicator_cfg_pkg::resp_slverr;
            if (st_reg.w_strb[0] || st_reg.w_strb[1])
            begin
                case (st_reg.aw_addr)
                    indicator_cfg_pkg::indicator_output_control_addr:
                    begin
                        for (int i = 0; i < 3; i++)
                        begin
                            if (st_reg.w_strb[(4*i)/8])
                            begin
                                st_next.ind.polarity[i]   = wr_val[4*i+2];
                                st_next.ind.ovr_value[i]  = wr_val[4*i+1];
                                st_next.ind.ovr_enable[i] = wr_val[4*i];
                            end
                        end
                    end
                    indicator_cfg_pkg::line_polarity_override_addr:
                    begin
                        if (st_reg.w_strb[0])
                            st_next.lpol[7:0] = wr_val[7:0];
                        if (st_reg.w_strb[1])
                            st_next.lpol[15:8] = wr_val[15:8];
                    end
                    indicator_cfg_pkg::monitor_period_config_addr:
                        if (st_reg.w_strb[0])
                            st_next.period = wr_val[3:0];
                    indicator_cfg_pkg::monitor_run_control_addr:
                    begin
                        if (st_reg.w_strb[0])
                        begin
                            st_next.periodic = wr_val[indicator_cfg_pkg::periodic_bit];
                            start_wr = wr_val[indicator_cfg_pkg::start_bit];
                        end
                        st_next.run_rsvd[5:0] = st_reg.w_strb[0] ? wr_val[7:2]
                                                                 : st_reg.run_rsvd[5:0];
                        st_next.run_rsvd[13:6] = st_reg.w_strb[1] ? wr_val[15:8]
                                                                  : st_reg.run_rsvd[13:6];
                    end
                    default:
                        st_next.bresp = indicator_cfg_pkg::resp_slverr;
                endcase
            end
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;

        // read channel
        st_next.arready = 1'b0;
        if (s_axi_arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata = {16'h0000, rd_val};
            st_next.rresp = rd_hit ? indicator_cfg_pkg::resp_okay
                                   : indicator_cfg_pkg::resp_slverr;
        end
        else if (s_axi_arvalid && !st_reg.rvalid)
            st_next.arready = 1'b1;
        if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;

        // monitor sequencing
        st_next.mon_trig = 1'b0;
        st_next.start = 1'b0;
        if (start_wr)
            st_next.start = 1'b1;
        case (st_reg.mon)
            indicator_cfg_pkg::mon_idle:
            begin
                if (st_reg.start)
                    st_next.mon = indicator_cfg_pkg::mon_fire;
            end
            indicator_cfg_pkg::mon_fire:
            begin
                st_next.mon_trig = 1'b1;
                st_next.unit_cnt = 24'h000000;
                st_next.per_cnt = 4'h1;
                st_next.mon = st_reg.periodic ? indicator_cfg_pkg::mon_wait
                                              : indicator_cfg_pkg::mon_idle;
            end
            indicator_cfg_pkg::mon_wait:
            begin
                st_next.unit_cnt = unit_tick ? 24'h000000 : st_reg.unit_cnt + 24'h000001;
                if (!st_reg.periodic)
                    st_next.mon = indicator_cfg_pkg::mon_idle;
                else if (st_reg.start)
                    st_next.mon = indicator_cfg_pkg::mon_fire;
                else if (unit_tick)
                begin
                    st_next.per_cnt = st_reg.per_cnt + 4'h1;
                    if (st_reg.per_cnt >= st_reg.period)
                        st_next.mon = indicator_cfg_pkg::mon_fire;
                end
            end
            default:
                st_next.mon = indicator_cfg_pkg::mon_idle;
        endcase

        // strap catch after reset release
        st_next.strap_done = {st_reg.strap_done[0], 1'b1};
        if (st_reg.strap_done == 2'b01)
            st_next.ind.polarity[1:0] = strap_polarity;

        // indicator pin synchroniser and drive
        st_next.act_s1 = light_active;
        st_next.act_s2 = st_reg.act_s1;
        st_next.act_s3 = st_reg.act_s2;
        for (int i = 0; i < 3; i++)
        begin
            if (st_reg.act_s2[i] == st_reg.act_s3[i])
                st_next.act_ok[i] = st_reg.act_s3[i];
            if (st_reg.ind.ovr_enable[i])
                st_next.light[i] = st_reg.ind.ovr_value[i];
            else
                st_next.light[i] = st_reg.ind.polarity[i] ? st_reg.act_ok[i]
                                                          : !st_reg.act_ok[i];
        end
        st_next.busy = (st_next.mon != indicator_cfg_pkg::mon_idle);
        st_next.rev = st_next.lpol.pol_force && st_next.lpol.pol_value;
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_reg <= '0;
            st_reg.ind.polarity[2] <= indicator_cfg_pkg::third_pol_reset;
            st_reg.period <= indicator_cfg_pkg::period_reset;
            st_reg.periodic <= indicator_cfg_pkg::periodic_reset;
            st_reg.run_rsvd <= indicator_cfg_pkg::run_ctrl_rsvd_reset;
            st_reg.mon <= indicator_cfg_pkg::mon_idle;
            st_reg.light <= 3'b111;
            st_reg.act_ok <= 3'b000;
        end
        else
            st_reg <= st_next;
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign s_axi_awready = !st_reg.aw_ok;
    assign s_axi_wready = !st_reg.w_ok;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign status_light = st_reg.light;
    assign auto_polarity_off = st_reg.lpol.pol_force;
    assign line_polarity_reversed = st_reg.rev;
    assign monitor_trigger = st_reg.mon_trig;
    assign monitor_busy = st_reg.busy;

endmodule // indicator_cfg_regs

// >>> sim/indicator_cfg_regs_properties.sv
`timescale 1ns/10ps
module indicator_cfg_regs_properties
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [2:0]  light_active,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [2:0]  status_light,
    input wire logic        auto_polarity_off,
    input wire logic        line_polarity_reversed,
    input wire logic        monitor_trigger,
    input wire logic        monitor_busy
);
    // ==========================================================
    // shadow of the last accepted write and age of light_active
    // ==========================================================
    logic [13:0] aw_a;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bv_q;
    logic [2:0]  third_sh;
    logic [2:0]  age;
    logic [2:0]  la_q;
    logic [2:0]  la_age;
    logic        wr_done;
    assign wr_done = s_axi_bvalid && !bv_q && (s_axi_bresp == indicator_cfg_pkg::resp_okay);

    always_ff @(posedge ref_clk)
    begin
        bv_q <= s_axi_bvalid;
        la_q <= light_active;
        la_age <= (light_active != la_q) ? 3'h0 : la_age + {2'h0, la_age != 3'h7};
        if (s_axi_awvalid && s_axi_awready)
            aw_a <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_d <= s_axi_wdata;
            w_s <= s_axi_wstrb;
        end
        if (reset)
        begin
            third_sh <= 3'h0;
            age <= 3'h0;
        end
        else if (wr_done && aw_a == indicator_cfg_pkg::indicator_output_control_addr && w_s[1])
        begin
            third_sh <= w_d[10:8];
            age <= 3'h0;
        end
        else
            age <= age + {2'h0, age != 3'h7};
    end

    // ==========================================================
    // properties
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_start_wr;
        wr_done && aw_a == indicator_cfg_pkg::monitor_run_control_addr && w_s[0] && w_d[0];
    endsequence
    sequence s_pol_wr;
        wr_done && aw_a == indicator_cfg_pkg::line_polarity_override_addr && w_s[1];
    endsequence

    property p_trig_pulse;
        monitor_trigger |=> !monitor_trigger;
    endproperty
    property p_start_fires;
        s_start_wr |-> ##[1:3] monitor_trigger;
    endproperty
    property p_start_busy;
        s_start_wr |-> ##[1:2] monitor_busy;
    endproperty
    property p_force;
        s_pol_wr |-> ##1 (auto_polarity_off == w_d[12]);
    endproperty
    property p_reverse;
        s_pol_wr |-> ##1 (line_polarity_reversed == (w_d[12] && w_d[13]));
    endproperty
    property p_rev_forced;
        line_polarity_reversed |-> auto_polarity_off;
    endproperty
    property p_override;
        third_sh[0] && age == 3'h7 |-> status_light[2] == third_sh[1];
    endproperty
    property p_polarity;
        !third_sh[0] && age == 3'h7 && la_age == 3'h7
            |-> status_light[2] == (light_active[2] ~^ third_sh[2]);
    endproperty

    a_trig_pulse: assert property (p_trig_pulse)
        else $error("monitor trigger longer than one cycle");
    a_start_fires: assert property (p_start_fires)
        else $error("start write gave no monitor trigger");
    a_start_busy: assert property (p_start_busy)
        else $error("start write did not make the monitor busy");
    a_force: assert property (p_force)
        else $error("auto polarity off does not follow force bit");
    a_reverse: assert property (p_reverse)
        else $error("reversed polarity does not follow value and force");
    a_rev_forced: assert property (p_rev_forced)
        else $error("reversed polarity without force");
    a_override: assert property (p_override)
        else $error("third light not at override level");
    a_polarity: assert property (p_polarity)
        else $error("third light polarity wrong");
endmodule // indicator_cfg_regs_properties

bind indicator_cfg_regs indicator_cfg_regs_properties indicator_cfg_regs_properties_inst
(
    .ref_clk(ref_clk), .reset(reset), .light_active(light_active),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .status_light(status_light), .auto_polarity_off(auto_polarity_off),
    .line_polarity_reversed(line_polarity_reversed), .monitor_trigger(monitor_trigger),
    .monitor_busy(monitor_busy)
);

// >>> sim/indicator_cfg_regs_test.sv
`timescale 1ns/10ps
module indicator_cfg_regs_test;
    localparam logic [13:0] a_ctl = indicator_cfg_pkg::indicator_output_control_addr;
    localparam logic [13:0] a_pol = indicator_cfg_pkg::line_polarity_override_addr;
    localparam logic [13:0] a_per = indicator_cfg_pkg::monitor_period_config_addr;
    localparam logic [13:0] a_run = indicator_cfg_pkg::monitor_run_control_addr;
    localparam logic [1:0]  ok    = indicator_cfg_pkg::resp_okay;
    localparam logic [1:0]  err   = indicator_cfg_pkg::resp_slverr;

    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [1:0]  strap_polarity = 2'h2;
    logic [2:0]  light_active = 3'h3;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  status_light;
    logic        auto_polarity_off, line_polarity_reversed, monitor_trigger, monitor_busy;
    int          fails = 0;
    int          checks = 0;
    int          trig_cnt = 0;
    int          base;
    int          i;
    logic [31:0] pv [4] = '{32'hffff, 32'h1000, 32'h2000, 32'h0000};

    indicator_cfg_regs indicator_cfg_regs_inst
    (
        .ref_clk(ref_clk), .reset(reset), .strap_polarity(strap_polarity),
        .light_active(light_active), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .status_light(status_light),
        .auto_polarity_off(auto_polarity_off), .line_polarity_reversed(line_polarity_reversed),
        .monitor_trigger(monitor_trigger), .monitor_busy(monitor_busy)
    );

    always #50 ref_clk = ~ref_clk;

    always @(negedge ref_clk)
        if (monitor_trigger === 1'b1)
            trig_cnt <= trig_cnt + 1;

    // ==========================================================
    // verdict and compare
    // ==========================================================
    task automatic results();
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stall();
        fails++;
        results();
    endtask

    // ==========================================================
    // bus tasks and status light check
    // ==========================================================
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        logic b;
        logic aw_t;
        logic w_t;
        b = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !b; n++)
        begin
            @(negedge ref_clk);
            aw_t = s_axi_awready && s_axi_awvalid;
            w_t = s_axi_wready && s_axi_wvalid;
            b = (s_axi_bvalid === 1'b1);
            if (b)
                cmp(32'(s_axi_bresp), 32'(er));
            @(posedge ref_clk);
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
            if (b)
                s_axi_bready <= 1'b0;
        end
        if (!b)
            stall();
    endtask

    task automatic rd(input logic [13:0] a, input logic [31:0] ex, input logic [1:0] er);
        int n;
        logic r;
        logic ar_t;
        r = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !r; n++)
        begin
            @(negedge ref_clk);
            ar_t = s_axi_arready && s_axi_arvalid;
            r = (s_axi_rvalid === 1'b1);
            if (r)
            begin
                cmp(32'(s_axi_rresp), 32'(er));
                if (er == ok)
                    cmp(s_axi_rdata, ex);
            end
            @(posedge ref_clk);
            if (ar_t)
                s_axi_arvalid <= 1'b0;
            if (r)
                s_axi_rready <= 1'b0;
        end
        if (!r)
            stall();
    endtask

    task automatic lights(input logic [2:0] e);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp(32'(status_light), 32'(e));
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(a_ctl, 32'h0040, ok);
        rd(a_pol, 32'h0000, ok);
        rd(a_per, 32'h0002, ok);
        rd(a_run, 32'h00a2, ok);
        rd(14'h0010, 32'h0, err);
        wr(14'h0010, 32'h1, 4'hf, err);
        lights(3'h6);
        wr(a_ctl, 32'hffff, 4'hf, ok);
        rd(a_ctl, 32'h0777, ok);
        lights(3'h7);
        wr(a_ctl, 32'h0515, 4'hf, ok);
        lights(3'h0);
        wr(a_ctl, 32'h0444, 4'hf, ok);
        lights(3'h3);
        wr(a_ctl, 32'hffff, 4'hc, ok);
        rd(a_ctl, 32'h0444, ok);
        wr(a_ctl, 32'h0000, 4'hf, ok);
        light_active <= 3'h6;
        lights(3'h1);
        for (i = 0; i < 4; i++)
        begin
            wr(a_pol, pv[i], 4'hf, ok);
            rd(a_pol, pv[i], ok);
            cmp(32'({auto_polarity_off, line_polarity_reversed}),
                32'({pv[i][12], pv[i][12] & pv[i][13]}));
        end
        wr(a_per, 32'hffff, 4'hf, ok);
        rd(a_per, 32'h000f, ok);
        base = trig_cnt;
        wr(a_run, 32'h00a1, 4'hf, ok);
        rd(a_run, 32'h00a0, ok);
        repeat (4) @(posedge ref_clk);
        cmp(32'(trig_cnt - base), 32'h1);
        cmp(32'(monitor_busy), 32'h0);
        wr(a_run, 32'h00a0, 4'hf, ok);
        repeat (4) @(posedge ref_clk);
        cmp(32'(trig_cnt - base), 32'h1);
        wr(a_run, 32'h00a3, 4'hf, ok);
        rd(a_run, 32'h00a2, ok);
        repeat (4) @(posedge ref_clk);
        cmp(32'(trig_cnt - base), 32'h2);
        cmp(32'(monitor_busy), 32'h1);
        results();
    end
endmodule // indicator_cfg_regs_test
